// ===== rtl/cofm_pkg.sv
package cofm_pkg;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [7:0] OP_OR_LITERAL_W = 8'h09;
  localparam logic [5:0] OP_OR_W_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE = 6'h14;
  localparam logic [3:0] OP_MOVE_FILE_FILE = 4'hc;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_MOVE_LITERAL_W = 8'h0e;
  localparam logic [6:0] OP_MOVE_W_FILE = 7'h37;
  localparam logic [7:0] OP_MUL_LITERAL = 8'h0d;
  localparam logic [6:0] OP_MUL_W_FILE = 7'h01;
  localparam logic [9:0] OP_LOAD_POINTER = 10'h3b8;
  localparam logic [5:0] OP_INC_SKIP_ZERO = 6'h0f;
  localparam logic [5:0] OP_INC_SKIP_NONZERO = 6'h12;

  // ****************************************************************
  // Addresses, fields and reset values
  // ****************************************************************
  localparam logic [11:0] ADDR_W = 12'hfe8;
  localparam logic [11:0] ADDR_PROG_COUNTER_LOW = 12'hff9;
  localparam logic [11:0] ADDR_STACK_TOP_LOW = 12'hffd;
  localparam logic [11:0] ADDR_STACK_TOP_HIGH = 12'hffe;
  localparam logic [11:0] ADDR_STACK_TOP_UPPER = 12'hfff;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam int BIT_DEST = 9;
  localparam int BIT_ACCESS = 8;
  localparam int BIT_FLAG_ZERO = 2;
  localparam int BIT_FLAG_SIGN = 4;
  localparam logic [1:0] POINTER_COUNT = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_POINTER = 12'h000;
  localparam int DATA_DEPTH = 4096;

  typedef enum logic [3:0] {
    COFM_Q1 = 4'b0001,
    COFM_Q2 = 4'b0010,
    COFM_Q3 = 4'b0100,
    COFM_Q4 = 4'b1000
  } cofm_phase_e;

  typedef enum logic [3:0] {
    COFM_ST_FETCH = 4'b0001,
    COFM_ST_MOVE_SECOND = 4'b0010,
    COFM_ST_POINTER_SECOND = 4'b0100,
    COFM_ST_IDLE = 4'b1000
  } cofm_state_e;

  typedef struct packed {
    logic [7:0] accum;
    logic [7:0] bank_select;
    logic [7:0] status;
    logic [7:0] product_high;
    logic [7:0] product_low;
  } cofm_core_s;

endpackage : cofm_pkg

// ===== rtl/cofm_exec.sv
`timescale 1ns/10ps
// How it works
// - or_literal_w ORs accumulator with literal into accumulator.
// - or_w_file ORs accumulator with file, result to chosen destination.
// - Both ORs and move_file change only sign and zero flags.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - Access bit 0 uses access bank, 1 uses bank_select.
// - move_file copies file to chosen destination in one cycle.
// - Eight-bit file field picks any byte of a 256-byte bank.
// - load_pointer loads 12-bit literal, high four bits first then low byte.
// - move_file_file moves between any of 4096 bytes, either may be W.
// - move_file_file reads source first cycle, writes at second's end.
// - load_bank writes literal into bank_select, no status change.
// - move_w_file copies accumulator to file, no status change.
// - mul_literal puts unsigned product in product pair, keeps W.
// - mul_w_file multiplies accumulator by file into product pair.
// - Multiplies change no status flag.
// - Phases: fetch, address, read and process, write.
// - Taken increment skip discards next instruction with idle cycle.
module cofm_exec (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [15:0] i_instr,
  output logic o_instr_take,
  output logic o_pc_advance,
  output cofm_pkg::cofm_phase_e o_phase,
  output cofm_pkg::cofm_core_s o_core,
  output logic [11:0] o_pointer0,
  output logic [11:0] o_pointer1,
  output logic [11:0] o_pointer2
);
  import cofm_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] mem [DATA_DEPTH];
  cofm_phase_e phase_q, phase_d;
  cofm_state_e state_q, state_d;
  cofm_core_s core_q, core_d;
  logic [11:0] ptr_q [3];
  logic [11:0] ptr_d [3];
  logic [15:0] ir_q, ir_d;
  logic [11:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [7:0] res_q, res_d;
  logic [15:0] prod_q, prod_d;
  logic [1:0] sel_q, sel_d;
  logic [3:0] hi_q, hi_d;
  logic skip_q, skip_d;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic [11:0] faddr;
  logic [7:0] rd_now;
  logic dest_file;

  // ****************************************************************
  // Address forming
  // ****************************************************************
  always_comb begin
    if (!ir_q[BIT_ACCESS]) begin
      faddr = (ir_q[7:0] < ACCESS_SPLIT) ? {4'h0, ir_q[7:0]}
                                         : {ACCESS_HIGH_BANK, ir_q[7:0]};
    end else begin
      faddr = {core_q.bank_select[3:0], ir_q[7:0]};
    end
  end

  assign rd_now = (addr_q == ADDR_W) ? core_q.accum : mem[addr_q];
  assign dest_file = ir_q[BIT_DEST];
  assign o_phase = phase_q;
  assign o_core = core_q;
  assign o_pointer0 = ptr_q[0];
  assign o_pointer1 = ptr_q[1];
  assign o_pointer2 = ptr_q[2];
  assign o_instr_take = (phase_q == COFM_Q1);
  assign o_pc_advance = (phase_q == COFM_Q4);

  // ****************************************************************
  // Four-phase sequencer and execution
  // ****************************************************************
  always_comb begin
    phase_d = phase_q;
    state_d = state_q;
    core_d = core_q;
    ir_d = ir_q;
    addr_d = addr_q;
    data_d = data_q;
    res_d = res_q;
    prod_d = prod_q;
    sel_d = sel_q;
    hi_d = hi_q;
    skip_d = skip_q;
    wr_en = 1'b0;
    wr_addr = addr_q;
    wr_data = res_q;
    for (int i = 0; i < 3; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    case (phase_q)
      COFM_Q1: begin
        phase_d = COFM_Q2;
        // Second words land in ir_q too, so their own bits name the target.
        ir_d = i_instr;
      end
      COFM_Q2: begin
        phase_d = COFM_Q3;
        if (state_q == COFM_ST_FETCH) begin
          if (ir_q[15:12] == OP_MOVE_FILE_FILE) begin
            addr_d = ir_q[11:0];
          end else begin
            addr_d = faddr;
          end
        end else if (state_q == COFM_ST_POINTER_SECOND) begin
          res_d = ir_q[7:0];
        end
      end
      COFM_Q3: begin
        phase_d = COFM_Q4;
        data_d = rd_now;
        if (state_q == COFM_ST_FETCH) begin
          if (ir_q[15:12] == OP_MOVE_FILE_FILE) begin
            res_d = rd_now;
          end else if (ir_q[15:8] == OP_OR_LITERAL_W) begin
            res_d = core_q.accum | ir_q[7:0];
          end else if (ir_q[15:10] == OP_OR_W_FILE) begin
            res_d = core_q.accum | rd_now;
          end else if (ir_q[15:8] == OP_MUL_LITERAL) begin
            prod_d = core_q.accum * ir_q[7:0];
          end else if (ir_q[15:9] == OP_MUL_W_FILE) begin
            prod_d = core_q.accum * rd_now;
          end else if (ir_q[15:10] == OP_INC_SKIP_ZERO ||
                       ir_q[15:10] == OP_INC_SKIP_NONZERO) begin
            res_d = rd_now + 8'h01;
          end else begin
            res_d = rd_now;
          end
        end
      end
      default: begin
        phase_d = COFM_Q1;
        if (state_q == COFM_ST_IDLE) begin
          state_d = skip_q ? COFM_ST_IDLE : COFM_ST_FETCH;
          skip_d = 1'b0;
        end else if (state_q == COFM_ST_MOVE_SECOND) begin
          state_d = COFM_ST_FETCH;
          wr_en = 1'b1;
          wr_addr = ir_q[11:0];
          wr_data = res_q;
        end else if (state_q == COFM_ST_POINTER_SECOND) begin
          state_d = COFM_ST_FETCH;
          ptr_d[sel_q] = {hi_q, ir_q[7:0]};
        end else if (ir_q[15:12] == OP_MOVE_FILE_FILE) begin
          state_d = COFM_ST_MOVE_SECOND;
        end else if (ir_q[15:6] == OP_LOAD_POINTER &&
                     ir_q[5:4] != POINTER_COUNT) begin
          state_d = COFM_ST_POINTER_SECOND;
          sel_d = ir_q[5:4];
          hi_d = ir_q[3:0];
          ptr_d[ir_q[5:4]] = {ir_q[3:0], ptr_q[ir_q[5:4]][7:0]};
        end else if (ir_q[15:8] == OP_OR_LITERAL_W) begin
          core_d.accum = res_q;
          core_d.status[BIT_FLAG_ZERO] = (res_q == 8'h00);
          core_d.status[BIT_FLAG_SIGN] = res_q[7];
        end else if (ir_q[15:10] == OP_OR_W_FILE ||
                     ir_q[15:10] == OP_MOVE_FILE) begin
          core_d.status[BIT_FLAG_ZERO] = (res_q == 8'h00);
          core_d.status[BIT_FLAG_SIGN] = res_q[7];
          if (dest_file) begin
            wr_en = 1'b1;
          end else begin
            core_d.accum = res_q;
          end
        end else if (ir_q[15:10] == OP_INC_SKIP_ZERO ||
                     ir_q[15:10] == OP_INC_SKIP_NONZERO) begin
          if (dest_file) begin
            wr_en = 1'b1;
          end else begin
            core_d.accum = res_q;
          end
          if ((res_q == 8'h00) == (ir_q[15:10] == OP_INC_SKIP_ZERO)) begin
            state_d = COFM_ST_IDLE;
            skip_d = 1'b0;
          end
        end else if (ir_q[15:8] == OP_LOAD_BANK) begin
          core_d.bank_select = ir_q[7:0];
        end else if (ir_q[15:8] == OP_MOVE_LITERAL_W) begin
          core_d.accum = ir_q[7:0];
        end else if (ir_q[15:9] == OP_MOVE_W_FILE) begin
          wr_en = 1'b1;
          wr_data = core_q.accum;
        end else if (ir_q[15:8] == OP_MUL_LITERAL ||
                     ir_q[15:9] == OP_MUL_W_FILE) begin
          core_d.product_high = prod_q[15:8];
          core_d.product_low = prod_q[7:0];
        end
        // The accumulator has a data-space address, so a file write there
        // lands in the core register instead of the array.
        if (wr_en && wr_addr == ADDR_W) begin
          core_d.accum = wr_data;
        end
        if (state_q == COFM_ST_IDLE && !skip_q) begin
          state_d = COFM_ST_FETCH;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase_q <= COFM_Q1;
      state_q <= COFM_ST_FETCH;
      core_q <= '0;
      ir_q <= 16'h0000;
      addr_q <= RESET_POINTER;
      data_q <= RESET_BYTE;
      res_q <= RESET_BYTE;
      prod_q <= 16'h0000;
      sel_q <= 2'h0;
      hi_q <= 4'h0;
      skip_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= RESET_POINTER;
      end
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
      core_q <= core_d;
      ir_q <= ir_d;
      addr_q <= addr_d;
      data_q <= data_d;
      res_q <= res_d;
      prod_q <= prod_d;
      sel_q <= sel_d;
      hi_q <= hi_d;
      skip_q <= skip_d;
      for (int i = 0; i < 3; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // The data space has no reset; software initialises it.
  always_ff @(posedge i_core_clk) begin
    if (wr_en && wr_addr != ADDR_W) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule : cofm_exec

// ===== verif/cofm_exec_properties.sv
`timescale 1ns/10ps
// ****************************************************************
// Port checks
// ****************************************************************
module cofm_exec_properties
  import cofm_pkg::*;
(
  input logic i_core_clk,
  input logic i_reset,
  input logic [15:0] i_instr,
  input logic o_instr_take,
  input logic o_pc_advance,
  input cofm_pkg::cofm_phase_e o_phase,
  input cofm_pkg::cofm_core_s o_core,
  input logic [11:0] o_pointer0
);
  logic skip_q;
  logic ok;
  logic [7:0] lit;
  logic [7:0] acc;
  logic [7:0] st;
  assign lit = i_instr[7:0];
  assign acc = o_core.accum;
  assign st = o_core.status;
  // A word taken after an increment-skip may be discarded.
  // A word taken after a two-word opener is an operand, not an opcode.
  assign ok = o_instr_take && !skip_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      skip_q <= 1'b0;
    end else if (o_instr_take) begin
      skip_q <= (i_instr[15:10] == OP_INC_SKIP_ZERO) ||
        (i_instr[15:10] == OP_INC_SKIP_NONZERO) ||
        (i_instr[15:12] == OP_MOVE_FILE_FILE) ||
        (i_instr[15:6] == OP_LOAD_POINTER);
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_phase_order: assert property (
    o_phase == COFM_Q1 |=> o_phase == COFM_Q2 ##1 o_phase == COFM_Q3
    ##1 o_phase == COFM_Q4 ##1 o_phase == COFM_Q1) else $error("phase order");
  a_take_in_q1: assert property (
    o_instr_take == (o_phase == COFM_Q1)) else $error("take not in Q1");
  a_advance_in_q4: assert property (
    o_pc_advance == (o_phase == COFM_Q4)) else $error("advance not in Q4");
  a_or_literal: assert property (
    ok && i_instr[15:8] == OP_OR_LITERAL_W |-> ##4
    acc == ($past(acc, 4) | $past(lit, 4)) && st[BIT_FLAG_ZERO] ==
    (acc == 8'h00) && st[BIT_FLAG_SIGN] == acc[7]) else $error("or literal");
  a_move_literal: assert property (
    ok && i_instr[15:8] == OP_MOVE_LITERAL_W |-> ##4
    acc == $past(lit, 4) && st == $past(st, 4)) else $error("move literal");
  a_load_bank: assert property (
    ok && i_instr[15:8] == OP_LOAD_BANK |-> ##4
    o_core.bank_select == $past(lit, 4) && st == $past(st, 4))
    else $error("load bank");
  a_mul_literal: assert property (
    ok && i_instr[15:8] == OP_MUL_LITERAL |-> ##4
    {o_core.product_high, o_core.product_low} ==
    ({8'h00, $past(acc, 4)} * {8'h00, $past(lit, 4)}) &&
    acc == $past(acc, 4) && st == $past(st, 4)) else $error("mul literal");
  a_mul_file_flags: assert property (
    ok && i_instr[15:9] == OP_MUL_W_FILE |-> ##4
    acc == $past(acc, 4) && st == $past(st, 4)) else $error("mul file");
  a_move_w_keeps: assert property (
    ok && i_instr[15:9] == OP_MOVE_W_FILE |-> ##4
    acc == $past(acc, 4) && st == $past(st, 4)) else $error("move w file");
  a_pointer_high: assert property (
    ok && i_instr[15:6] == OP_LOAD_POINTER && i_instr[5:4] == 2'h0 |-> ##4
    o_pointer0[11:8] == $past(i_instr[3:0], 4)) else $error("pointer high");
endmodule : cofm_exec_properties

bind cofm_exec cofm_exec_properties u_props (
  .i_core_clk(i_core_clk),
  .i_reset(i_reset),
  .i_instr(i_instr),
  .o_instr_take(o_instr_take),
  .o_pc_advance(o_pc_advance),
  .o_phase(o_phase),
  .o_core(o_core),
  .o_pointer0(o_pointer0)
);

// ===== verif/test_cofm_exec.sv
`timescale 1ns/10ps
// ****************************************************************
// Bench with reference model
// ****************************************************************
module test_cofm_exec;
  import cofm_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic o_instr_take;
  cofm_phase_e o_phase;
  cofm_core_s o_core;
  cofm_core_s m;
  logic [11:0] o_pointer0, o_pointer1, o_pointer2;
  logic [11:0] mp [4];
  logic [7:0] mem [4096];
  logic [7:0] sv;
  logic [1:0] stage;
  logic [1:0] pix;
  logic skip;
  logic [31:0] seed = 32'hbe163e17;
  int bad_count = 0;
  int tests_run = 0;
  int i;
  always #25 i_core_clk = ~i_core_clk;
  cofm_exec uut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_instr(i_instr), .o_instr_take(o_instr_take), .o_pc_advance(),
    .o_phase(o_phase), .o_core(o_core), .o_pointer0(o_pointer0),
    .o_pointer1(o_pointer1), .o_pointer2(o_pointer2));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function logic [11:0] fa(input logic [15:0] x);
    if (x[BIT_ACCESS]) return {m.bank_select[3:0], x[7:0]};
    return x[7] ? {ACCESS_HIGH_BANK, x[7:0]} : {4'h0, x[7:0]};
  endfunction : fa
  function automatic logic [11:0] ra(input logic [4:0] r);
    return {2'h0, r[4], 5'h00, r[3:0]};
  endfunction : ra
  task wr(input logic [11:0] a, input logic [7:0] v);
    if (a == ADDR_W) m.accum = v;
    else mem[a] = v;
  endtask : wr
  task dst(input logic [15:0] x, input logic [7:0] v);
    if (x[BIT_DEST]) wr(fa(x), v);
    else m.accum = v;
  endtask : dst
  task nz(input logic [7:0] v);
    m.status[BIT_FLAG_ZERO] = v == 8'h00;
    m.status[BIT_FLAG_SIGN] = v[7];
  endtask : nz
  task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apply(input logic [15:0] x);
    logic [7:0] v;
    v = (fa(x) == ADDR_W) ? m.accum : mem[fa(x)];
    if (skip) skip = 1'b0;
    else if (stage == 2'h1) begin
      stage = 2'h0;
      wr(x[11:0], sv);
    end else if (stage == 2'h2) begin
      stage = 2'h0;
      mp[pix][7:0] = x[7:0];
    end else if (x[15:8] == OP_OR_LITERAL_W) begin
      m.accum = m.accum | x[7:0];
      nz(m.accum);
    end else if (x[15:10] == OP_OR_W_FILE) begin
      nz(v | m.accum);
      dst(x, v | m.accum);
    end else if (x[15:10] == OP_MOVE_FILE) begin
      nz(v);
      dst(x, v);
    end else if (x[15:12] == OP_MOVE_FILE_FILE) begin
      sv = (x[11:0] == ADDR_W) ? m.accum : mem[x[11:0]];
      stage = 2'h1;
    end else if (x[15:8] == OP_LOAD_BANK) m.bank_select = x[7:0];
    else if (x[15:8] == OP_MOVE_LITERAL_W) m.accum = x[7:0];
    else if (x[15:9] == OP_MOVE_W_FILE) wr(fa(x), m.accum);
    else if (x[15:8] == OP_MUL_LITERAL) begin
      {m.product_high, m.product_low} = m.accum * x[7:0];
    end else if (x[15:9] == OP_MUL_W_FILE) begin
      {m.product_high, m.product_low} = m.accum * v;
    end else if (x[15:6] == OP_LOAD_POINTER) begin
      pix = x[5:4];
      mp[pix][11:8] = x[3:0];
      stage = 2'h2;
    end else if (x[15:10] == OP_INC_SKIP_ZERO ||
      x[15:10] == OP_INC_SKIP_NONZERO) begin
      dst(x, v + 8'h01);
      skip = ((v + 8'h01) == 8'h00) == (x[15:10] == OP_INC_SKIP_ZERO);
    end
  endtask : apply
  task issue(input logic [15:0] x);
    for (int n = 0; n < 8 && o_instr_take !== 1'b1; n++) @(negedge i_core_clk);
    chk("take", {39'h0, o_instr_take}, 40'h1);
    chk("core", o_core, m);
    chk("ptr", {4'h0, o_pointer0, o_pointer1, o_pointer2},
      {4'h0, mp[0], mp[1], mp[2]});
    i_instr = x;
    @(negedge i_core_clk);
    apply(x);
  endtask : issue
  task end_of_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
  initial begin
    m = '0;
    mp = '{default: 12'h000};
    {stage, skip} = 3'h0;
    repeat (6) @(negedge i_core_clk);
    i_reset = 1'b0;
    issue({OP_MOVE_LITERAL_W, 8'h9a});
    issue({OP_OR_LITERAL_W, 8'h35});
    issue({OP_MOVE_LITERAL_W, 8'h00});
    issue({OP_OR_LITERAL_W, 8'h00});
    issue({OP_LOAD_BANK, 8'h02});
    for (i = 0; i < 32; i++) begin
      seed = xs(seed);
      issue({OP_MOVE_LITERAL_W, seed[7:0]});
      issue({OP_MOVE_W_FILE, i[4], 4'h0, i[3:0]});
    end
    // The upper access half reaches the accumulator's own address.
    issue({OP_MOVE_FILE, 2'b00, 8'he8});
    issue({OP_OR_W_FILE, 2'b10, 8'he8});
    for (i = 0; i < 2; i++) begin
      issue({OP_MOVE_LITERAL_W, 8'hff});
      issue({OP_MOVE_W_FILE, 1'b0, 8'h05});
      issue({i[0] ? OP_INC_SKIP_NONZERO : OP_INC_SKIP_ZERO, 2'b10, 8'h05});
      issue({OP_MOVE_LITERAL_W, 8'h55});
      issue({OP_MOVE_FILE, 2'b00, 8'h05});
    end
    repeat (300) begin
      seed = xs(seed);
      if (seed[23:21] == 3'h0) begin
        issue({OP_MOVE_FILE_FILE, seed[28] ? ADDR_W : ra(seed[4:0])});
        // Targets stay in ordinary memory or the accumulator.
        issue({OP_SECOND_WORD, seed[27] ? ADDR_W : ra(seed[12:8])});
      end else if (seed[23:21] == 3'h1) begin
        issue({OP_LOAD_POINTER, seed[5:4] == 2'h3 ? 2'h0 : seed[5:4],
          seed[11:8]});
        issue({8'hf0, seed[19:12]});
      end else case (seed[19:16])
        4'h0: issue({OP_OR_LITERAL_W, seed[15:8]});
        4'h1: issue({OP_OR_W_FILE, seed[5:4], 4'h0, seed[3:0]});
        4'h2: issue({OP_MOVE_FILE, seed[5:4], 4'h0, seed[3:0]});
        4'h3: issue({OP_LOAD_BANK, 6'h00, seed[6], 1'b0});
        4'h4: issue({OP_MOVE_LITERAL_W, seed[15:8]});
        4'h5: issue({OP_MOVE_W_FILE, seed[5], 4'h0, seed[3:0]});
        4'h6: issue({OP_MUL_LITERAL, seed[15:8]});
        4'h7: issue({OP_MUL_W_FILE, seed[5], 4'h0, seed[3:0]});
        4'h8: issue({OP_INC_SKIP_ZERO, seed[5:4], 4'h0, seed[3:0]});
        4'h9: issue({OP_INC_SKIP_NONZERO, seed[5:4], 4'h0, seed[3:0]});
        default: issue({OP_MOVE_FILE_FILE, ADDR_W});
      endcase
    end
    issue(16'h0000);
    issue(16'h0000);
    end_of_test();
  end
endmodule : test_cofm_exec
